/* hdl/atc_pkg.sv */
package atc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TRIG    = 8'h04;
  localparam logic [7:0] OFS_TOTAL   = 8'h08;
  localparam logic [7:0] OFS_PRETRIG = 8'h0c;
  localparam logic [7:0] OFS_LEVEL   = 8'h10;
  localparam logic [7:0] OFS_DIV     = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_DATA    = 8'h1c;

  // Control register bits
  localparam int CTRL_GO      = 0;
  localparam int CTRL_ABORT   = 1;
  localparam int CTRL_CLR_ERR = 2;
  localparam int CTRL_FIXED   = 4;
  localparam int CTRL_SHARED  = 5;
  localparam int CTRL_CMP_PFI = 6;

  // Trigger configuration write fields
  localparam int TC_TYPE_LSB = 0;
  localparam int TC_EN       = 3;
  localparam int TC_STOP     = 4;
  localparam int TC_COND_LSB = 5;
  localparam int WIN_LSB     = 16;

  // Trigger type codes
  localparam logic [2:0] TT_NONE     = 3'h0;
  localparam logic [2:0] TT_ANALOG   = 3'h1;
  localparam logic [2:0] TT_DIG_A    = 3'h2;
  localparam logic [2:0] TT_DIG_B    = 3'h3;
  localparam logic [2:0] TT_GATE_DIG = 3'h4;
  localparam logic [2:0] TT_GATE_ANA = 3'h5;
  localparam logic [2:0] TT_EXPORT   = 3'h6;

  // Comparator conditions
  localparam logic [2:0] COND_RISE = 3'h1;
  localparam logic [2:0] COND_FALL = 3'h2;

  // Scan clock gate modes
  localparam logic [1:0] GATE_OFF = 2'h0;
  localparam logic [1:0] GATE_DIG = 2'h1;
  localparam logic [1:0] GATE_ANA = 2'h2;

  // Values after reset
  localparam logic [31:0] RST_TOTAL   = 32'h0000_0000;
  localparam logic [31:0] RST_PRETRIG = 32'h0000_0000;
  localparam logic [31:0] RST_DIV     = 32'h0000_0008;
  localparam logic [15:0] RST_LEVEL   = 16'h0000;
  localparam logic [15:0] RST_WINDOW  = 16'h0000;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT_START, ST_PRE, ST_POST, ST_DONE} atc_state_t;

  function automatic logic [4:0] atc_rise(input logic [4:0] cur, input logic [4:0] prev);
    atc_rise = cur & ~prev;
  endfunction

  function automatic logic atc_pick(input logic [2:0] src, input logic ana, input logic a, input logic b);
    case (src)
      TT_ANALOG: atc_pick = ana;
      TT_DIG_A:  atc_pick = a;
      TT_DIG_B:  atc_pick = b;
      default:   atc_pick = 1'b0;
    endcase
  endfunction

endpackage

/* hdl/atc_scan_ram.sv */
`timescale 1ns/1ns
module atc_scan_ram #(
  parameter int DATA_W = 16,
  parameter int AW     = 10
) (
  // Clock
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_clk_en,
  // Write port
  input  wire logic              i_we,
  input  wire logic [AW-1:0]     i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0]     i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk) begin
    if (i_clk_en && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

/* hdl/atc_trigger_ctrl.sv */
`timescale 1ns/1ns
module atc_trigger_ctrl #(
  parameter int DATA_W = 16,
  parameter int DEPTH  = 1024
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_clk_en,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Trigger sources
  input  wire logic              i_dig_trig_a,
  input  wire logic              i_dig_trig_b,
  input  wire logic              i_dedicated_start_pin,
  input  wire logic              i_dedicated_stop_pin,
  input  wire logic              i_external_trigger_pin,
  input  wire logic              i_external_gate_pin,
  input  wire logic [15:0]       i_analog_channel,
  input  wire logic [15:0]       i_first_programmable_trigger_input,
  // Scan side
  input  wire logic [DATA_W-1:0] i_scan_data,
  output logic                   o_scan_tick,
  output logic                   o_scan_active,
  output logic                   o_acq_done,
  output logic                   o_analog_comparator_output
);
  import atc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DATA_W < 1 || DATA_W > 32) begin : g_bad_param
    $error("DEPTH must be a power of two and DATA_W 1..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and bus
  logic        fixed_ff, shared_ff, cmp_pfi_ff, export_ff;
  logic        nxt_fixed, nxt_shared, nxt_cmp_pfi, nxt_export;
  logic [2:0]  start_src_ff, stop_src_ff, cmp_cond_ff;
  logic [2:0]  nxt_start_src, nxt_stop_src, nxt_cmp_cond;
  logic [1:0]  gate_mode_ff, nxt_gate_mode;
  logic [31:0] total_ff, pretrig_ff, div_ff, prdata_ff;
  logic [31:0] nxt_total, nxt_pretrig, nxt_div, nxt_prdata;
  logic [15:0] level_stage_ff, win_stage_ff, cmp_level_ff, cmp_win_ff;
  logic [15:0] nxt_level_stage, nxt_win_stage, nxt_cmp_level, nxt_cmp_win;
  logic        wr_acc, known, go_req, abort_req, clr_err_req, trig_bad, pop_req;
  logic [2:0]  tc_type, tc_cond;

  // Acquisition state
  atc_state_t        state_ff, nxt_state;
  logic              err_ff, nxt_err;
  logic              cmp_state_ff, nxt_cmp_state, cmp_out_q_ff, nxt_cmp_out_q;
  logic [4:0]        pins_q_ff, nxt_pins_q, pins_now, pin_edge;
  logic [31:0]       div_cnt_ff, nxt_div_cnt, pre_kept_ff, nxt_pre_kept, post_cnt_ff, nxt_post_cnt;
  logic [AW-1:0]     wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]       avail_ff, nxt_avail;
  logic [15:0]       cmp_in;
  logic [16:0]       cmp_hi;
  logic              cmp_out, cmp_fire, start_ev, stop_ev, gate_open, running, scan_tick, go_ok;
  logic [DATA_W-1:0] ram_rdata;

  always_comb begin
    wr_acc      = i_psel & i_penable & i_pwrite;
    known       = (i_paddr == OFS_CTRL) || (i_paddr == OFS_TRIG) || (i_paddr == OFS_TOTAL) ||
                  (i_paddr == OFS_PRETRIG) || (i_paddr == OFS_LEVEL) || (i_paddr == OFS_DIV) ||
                  (i_paddr == OFS_STATUS) || (i_paddr == OFS_DATA);
    tc_type     = i_pwdata[TC_TYPE_LSB +: 3];
    tc_cond     = i_pwdata[TC_COND_LSB +: 3];
    go_req      = wr_acc && i_paddr == OFS_CTRL && i_pwdata[CTRL_GO];
    abort_req   = wr_acc && i_paddr == OFS_CTRL && i_pwdata[CTRL_ABORT];
    clr_err_req = wr_acc && i_paddr == OFS_CTRL && i_pwdata[CTRL_CLR_ERR];
    pop_req     = i_psel && i_penable && !i_pwrite && i_paddr == OFS_DATA;
    trig_bad    = 1'b0;
    nxt_fixed = fixed_ff; nxt_shared = shared_ff; nxt_cmp_pfi = cmp_pfi_ff; nxt_export = export_ff;
    nxt_start_src = start_src_ff; nxt_stop_src = stop_src_ff; nxt_cmp_cond = cmp_cond_ff;
    nxt_gate_mode = gate_mode_ff; nxt_total = total_ff; nxt_pretrig = pretrig_ff; nxt_div = div_ff;
    nxt_level_stage = level_stage_ff; nxt_win_stage = win_stage_ff;
    nxt_cmp_level = cmp_level_ff; nxt_cmp_win = cmp_win_ff;
    nxt_prdata = prdata_ff;
    if (wr_acc) begin
      case (i_paddr)
        OFS_CTRL: begin
          nxt_fixed   = i_pwdata[CTRL_FIXED];
          nxt_shared  = i_pwdata[CTRL_SHARED];
          nxt_cmp_pfi = i_pwdata[CTRL_CMP_PFI];
        end
        OFS_TRIG: begin
          case (tc_type)
            TT_ANALOG, TT_DIG_A, TT_DIG_B: begin
              if (i_pwdata[TC_STOP]) begin
                if (tc_type == TT_DIG_B && i_pwdata[TC_EN]) begin
                  trig_bad = 1'b1;
                end else begin
                  nxt_stop_src = i_pwdata[TC_EN] ? tc_type : TT_NONE;
                end
              end else begin
                nxt_start_src = i_pwdata[TC_EN] ? tc_type : TT_NONE;
              end
            end
            TT_GATE_DIG: begin
              nxt_gate_mode = i_pwdata[TC_EN] ? GATE_DIG : GATE_OFF;
            end
            TT_GATE_ANA: begin
              // Both types drive one gate, so this replaces a digital gate
              if (i_pwdata[TC_EN]) begin
                nxt_gate_mode = GATE_ANA;
              end else if (gate_mode_ff == GATE_ANA) begin
                nxt_gate_mode = GATE_OFF;
              end
            end
            TT_EXPORT: begin
              nxt_export = i_pwdata[TC_EN];
            end
            default: begin
              trig_bad = 1'b1;
            end
          endcase
          // One comparator: the latest enable among 1, 5, 6 sets it up
          if (i_pwdata[TC_EN] && (tc_type == TT_ANALOG || tc_type == TT_GATE_ANA || tc_type == TT_EXPORT)) begin
            nxt_cmp_level = level_stage_ff;
            nxt_cmp_win   = win_stage_ff;
            nxt_cmp_cond  = tc_cond;
          end
        end
        OFS_TOTAL:   nxt_total = i_pwdata;
        OFS_PRETRIG: nxt_pretrig = i_pwdata;
        OFS_LEVEL: begin
          nxt_level_stage = i_pwdata[15:0];
          nxt_win_stage   = i_pwdata[WIN_LSB +: 16];
        end
        OFS_DIV: nxt_div = i_pwdata;
        default: ;
      endcase
    end
    // Read data is latched in the setup cycle and held through the access
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        OFS_CTRL:    nxt_prdata = {25'h0, cmp_pfi_ff, shared_ff, fixed_ff, 4'h0};
        OFS_TRIG:    nxt_prdata = {20'h0, cmp_cond_ff, export_ff, gate_mode_ff, stop_src_ff, start_src_ff};
        OFS_TOTAL:   nxt_prdata = total_ff;
        OFS_PRETRIG: nxt_prdata = pretrig_ff;
        OFS_LEVEL:   nxt_prdata = {win_stage_ff, level_stage_ff};
        OFS_DIV:     nxt_prdata = div_ff;
        OFS_STATUS:  nxt_prdata = {16'(avail_ff), 10'h0, gate_open, cmp_out, err_ff, 3'(state_ff)};
        OFS_DATA:    nxt_prdata = 32'(ram_rdata);
        default:     nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fixed_ff <= 1'b0; shared_ff <= 1'b0; cmp_pfi_ff <= 1'b0; export_ff <= 1'b0;
      start_src_ff <= TT_NONE; stop_src_ff <= TT_NONE; cmp_cond_ff <= COND_RISE;
      gate_mode_ff <= GATE_OFF; total_ff <= RST_TOTAL; pretrig_ff <= RST_PRETRIG; div_ff <= RST_DIV;
      level_stage_ff <= RST_LEVEL; win_stage_ff <= RST_WINDOW;
      cmp_level_ff <= RST_LEVEL; cmp_win_ff <= RST_WINDOW;
      prdata_ff <= 32'h0000_0000;
    end else if (i_clk_en) begin
      fixed_ff <= nxt_fixed; shared_ff <= nxt_shared; cmp_pfi_ff <= nxt_cmp_pfi; export_ff <= nxt_export;
      start_src_ff <= nxt_start_src; stop_src_ff <= nxt_stop_src; cmp_cond_ff <= nxt_cmp_cond;
      gate_mode_ff <= nxt_gate_mode; total_ff <= nxt_total; pretrig_ff <= nxt_pretrig; div_ff <= nxt_div;
      level_stage_ff <= nxt_level_stage; win_stage_ff <= nxt_win_stage;
      cmp_level_ff <= nxt_cmp_level; cmp_win_ff <= nxt_cmp_win;
      prdata_ff <= nxt_prdata;
    end
  end

  assign o_prdata  = prdata_ff;
  assign o_pready  = i_clk_en;
  assign o_pslverr = i_psel & i_penable & ~known;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator, trigger events, scan clock and sequencing
  always_comb begin
    // Signal on the programmable input avoids scan-list limits
    cmp_in        = cmp_pfi_ff ? i_first_programmable_trigger_input : i_analog_channel;
    cmp_hi        = {1'b0, cmp_level_ff} + {1'b0, cmp_win_ff};
    nxt_cmp_state = cmp_state_ff;
    // Window acts as hysteresis so noise near the level cannot retrigger
    if ({1'b0, cmp_in} >= cmp_hi) begin
      nxt_cmp_state = 1'b1;
    end else if (cmp_in < cmp_level_ff) begin
      nxt_cmp_state = 1'b0;
    end
    cmp_out       = (cmp_cond_ff == COND_FALL) ? ~cmp_state_ff : cmp_state_ff;
    cmp_fire      = cmp_out & ~cmp_out_q_ff;
    nxt_cmp_out_q = cmp_out;

    pins_now   = {i_external_trigger_pin, i_dedicated_stop_pin, i_dedicated_start_pin, i_dig_trig_b, i_dig_trig_a};
    nxt_pins_q = pins_now;
    pin_edge   = atc_rise(pins_now, pins_q_ff);
    if (shared_ff) begin
      start_ev = (start_src_ff != TT_NONE) && pin_edge[4];
      stop_ev  = (stop_src_ff != TT_NONE) && pin_edge[4];
    end else if (fixed_ff) begin
      start_ev = (start_src_ff != TT_NONE) && pin_edge[2];
      stop_ev  = (stop_src_ff != TT_NONE) && pin_edge[3];
    end else begin
      start_ev = atc_pick(start_src_ff, cmp_fire, pin_edge[0], pin_edge[1]);
      stop_ev  = atc_pick(stop_src_ff, cmp_fire, pin_edge[0], pin_edge[1]);
    end

    case (gate_mode_ff)
      GATE_DIG: gate_open = i_external_gate_pin;
      GATE_ANA: gate_open = cmp_out;
      default:  gate_open = 1'b1;
    endcase
    running     = (state_ff == ST_PRE) || (state_ff == ST_POST);
    scan_tick   = running && gate_open && (div_cnt_ff + 32'd1 >= div_ff);
    // Closed gate holds the divider where it is, so the scan resumes in place
    nxt_div_cnt = div_cnt_ff;
    if (running && gate_open) begin
      nxt_div_cnt = scan_tick ? 32'h0000_0000 : div_cnt_ff + 32'd1;
    end
    nxt_wr_ptr = scan_tick ? wr_ptr_ff + 1'b1 : wr_ptr_ff;

    go_ok = (total_ff != 32'h0000_0000) && (total_ff <= 32'(DEPTH));
    if (pretrig_ff == 32'h0000_0000) begin
      go_ok = go_ok && (start_src_ff != TT_DIG_B);
    end else begin
      go_ok = go_ok && (pretrig_ff < total_ff) && (stop_src_ff != TT_NONE) &&
              (start_src_ff != TT_DIG_A);
    end

    nxt_state    = state_ff;
    nxt_err      = err_ff;
    nxt_pre_kept = pre_kept_ff;
    nxt_post_cnt = post_cnt_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_avail    = avail_ff;
    if (pop_req && avail_ff != '0) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
      nxt_avail  = avail_ff - 1'b1;
    end
    case (state_ff)
      ST_IDLE, ST_DONE: begin
        if (go_req && go_ok) begin
          nxt_pre_kept = 32'h0000_0000;
          nxt_post_cnt = 32'h0000_0000;
          nxt_avail    = '0;
          if (start_src_ff != TT_NONE) begin
            nxt_state = ST_WAIT_START;
          end else if (pretrig_ff == 32'h0000_0000) begin
            nxt_state = ST_POST;
          end else begin
            nxt_state = ST_PRE;
          end
        end
      end
      ST_WAIT_START: begin
        if (start_ev) begin
          nxt_state = (pretrig_ff == 32'h0000_0000) ? ST_POST : ST_PRE;
        end
      end
      ST_PRE: begin
        // Older scans stay in the ring but fall outside the kept window
        if (scan_tick && pre_kept_ff < pretrig_ff) begin
          nxt_pre_kept = pre_kept_ff + 32'd1;
        end
        // Stop is honoured only once the pretrigger window is full
        if (stop_ev && pre_kept_ff >= pretrig_ff) begin
          nxt_state = ST_POST;
        end
      end
      ST_POST: begin
        if (scan_tick) begin
          nxt_post_cnt = post_cnt_ff + 32'd1;
          if (post_cnt_ff + 32'd1 >= total_ff - pretrig_ff) begin
            nxt_state  = ST_DONE;
            nxt_rd_ptr = nxt_wr_ptr - AW'(total_ff);
            nxt_avail  = (AW+1)'(total_ff);
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (abort_req) begin
      nxt_state = ST_IDLE;
    end
    // A new error in the clearing cycle wins
    if (clr_err_req) begin
      nxt_err = 1'b0;
    end
    if (trig_bad || (go_req && !go_ok)) begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= ST_IDLE; err_ff <= 1'b0; cmp_state_ff <= 1'b0; cmp_out_q_ff <= 1'b0;
      pins_q_ff <= 5'h1f; div_cnt_ff <= 32'h0000_0000; pre_kept_ff <= 32'h0000_0000;
      post_cnt_ff <= 32'h0000_0000; wr_ptr_ff <= '0; rd_ptr_ff <= '0; avail_ff <= '0;
    end else if (i_clk_en) begin
      state_ff <= nxt_state; err_ff <= nxt_err; cmp_state_ff <= nxt_cmp_state; cmp_out_q_ff <= nxt_cmp_out_q;
      pins_q_ff <= nxt_pins_q; div_cnt_ff <= nxt_div_cnt; pre_kept_ff <= nxt_pre_kept;
      post_cnt_ff <= nxt_post_cnt; wr_ptr_ff <= nxt_wr_ptr; rd_ptr_ff <= nxt_rd_ptr; avail_ff <= nxt_avail;
    end
  end

  atc_scan_ram #(
    .DATA_W (DATA_W),
    .AW     (AW)
  ) u_ram (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_we      (scan_tick),
    .i_waddr   (wr_ptr_ff),
    .i_wdata   (i_scan_data),
    .i_raddr   (rd_ptr_ff),
    .o_rdata   (ram_rdata)
  );

  assign o_scan_tick                = scan_tick;
  assign o_scan_active              = running & gate_open;
  assign o_acq_done                 = (state_ff == ST_DONE);
  assign o_analog_comparator_output = export_ff & cmp_out;

endmodule

/* sim/atc_trigger_ctrl_assertions.sv */
`timescale 1ns/1ns
module atc_trigger_ctrl_checker
  import atc_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_clk_en,
  // Scan side
  input wire logic        o_scan_tick,
  input wire logic        o_scan_active,
  input wire logic        o_acq_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic acc;
  logic go_wr;
  assign acc   = i_psel & i_penable;
  assign go_wr = acc & i_pwrite & (i_paddr == OFS_CTRL) & (i_pwdata[CTRL_GO] | i_pwdata[CTRL_ABORT]);

  a_ready_en: assert property (acc |-> o_pready == i_clk_en) else $error("pready not equal to clock enable");
  a_err_unmapped: assert property (acc && i_paddr > OFS_DATA |-> o_pslverr) else $error("no error on unmapped");
  a_ok_mapped: assert property (acc && i_paddr[1:0] == 2'h0 && i_paddr <= OFS_DATA |-> !o_pslverr)
    else $error("error on mapped address");
  a_done_holds: assert property (o_acq_done && !go_wr |=> o_acq_done) else $error("done dropped");
  a_done_no_tick: assert property (o_acq_done |-> !o_scan_tick && !o_scan_active)
    else $error("scan after done");
  a_tick_active: assert property (o_scan_tick |-> o_scan_active) else $error("tick while gated");
  a_idle_reset: assert property ($fell(i_sys_rst) |-> !o_acq_done && !o_scan_tick)
    else $error("not idle after reset");
  // Read data only moves after a setup cycle, so a stale value cannot pass for fresh
  a_rdata_hold: assert property (!$past(i_psel && !i_penable) |-> $stable(o_prdata))
    else $error("read data changed");
  c_done: cover property ($rose(o_acq_done));
  c_tick: cover property (o_scan_tick ##1 !o_scan_active);
  c_err: cover property (acc && o_pslverr);
endmodule

bind atc_trigger_ctrl atc_trigger_ctrl_checker i_chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_clk_en, .o_scan_tick, .o_scan_active, .o_acq_done);

/* sim/atc_src_model.sv */
`timescale 1ns/1ns
module atc_src_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Commands from bench
  input  wire logic        i_fire_a,
  input  wire logic        i_fire_b,
  input  wire logic        i_gate_open,
  input  wire logic        i_ramp,
  // Source lines
  output logic             o_dig_trig_a,
  output logic             o_dig_trig_b,
  output logic             o_external_gate_pin,
  output logic [15:0]      o_prog_input
);
  logic [1:0]  a_cnt_ff;
  logic [1:0]  b_cnt_ff;
  logic [15:0] ana_ff;
  // Pulses last two cycles, then the line falls to its pull-down level
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      a_cnt_ff            <= 2'h0;
      b_cnt_ff            <= 2'h0;
      ana_ff              <= 16'h0000;
      o_external_gate_pin <= 1'b1;
    end else begin
      a_cnt_ff            <= i_fire_a ? 2'h2 : a_cnt_ff - {1'b0, a_cnt_ff != 2'h0};
      b_cnt_ff            <= i_fire_b ? 2'h2 : b_cnt_ff - {1'b0, b_cnt_ff != 2'h0};
      ana_ff              <= i_ramp ? (ana_ff >= 16'hff00 ? ana_ff : ana_ff + 16'h0100) : 16'h0000;
      o_external_gate_pin <= i_gate_open;
    end
  end
  assign o_dig_trig_a = a_cnt_ff != 2'h0;
  assign o_dig_trig_b = b_cnt_ff != 2'h0;
  // Analog source sits on the programmable input, never on a scanned channel
  assign o_prog_input = ana_ff;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import atc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd;
  logic        pready, pslverr, tick, active, done, cmp_out, trig_a, trig_b, gate_pin;
  logic        fire_a = 1'b0, fire_b = 1'b0, gate = 1'b1, ramp = 1'b0;
  logic        clk_en = 1'b1, ext_pin = 1'b0;
  logic [15:0] prog_in, base, mark, scan_data = 16'h0000;
  logic [31:0] exp_q[$], msk_q[$];
  logic        err_q[$];
  logic [31:0] texp [6] = '{32'h1, 32'h2, 32'h3, 32'h40, 32'h80, 32'h100};
  logic [31:0] tmsk [6] = '{32'h7, 32'h7, 32'h7, 32'hc0, 32'hc0, 32'h100};
  int          fail_count = 0, n_tests = 0, seed = 29;

  always #4 clk = ~clk;

  atc_trigger_ctrl #(.DATA_W(16), .DEPTH(16)) i_atc_trigger_ctrl (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_dig_trig_a(trig_a), .i_dig_trig_b(trig_b),
    .i_dedicated_start_pin(1'b0), .i_dedicated_stop_pin(1'b0), .i_external_trigger_pin(ext_pin),
    .i_external_gate_pin(gate_pin), .i_analog_channel(16'h0000), .i_first_programmable_trigger_input(prog_in),
    .i_scan_data(scan_data), .o_scan_tick(tick), .o_scan_active(active), .o_acq_done(done),
    .o_analog_comparator_output(cmp_out));

  atc_src_model i_atc_src_model (.i_clk(clk), .i_sys_rst(rst), .i_fire_a(fire_a), .i_fire_b(fire_b),
    .i_gate_open(gate), .i_ramp(ramp), .o_dig_trig_a(trig_a), .o_dig_trig_b(trig_b),
    .o_external_gate_pin(gate_pin), .o_prog_input(prog_in));

  // Sample value equals its scan number
  always @(posedge clk) if (tick) scan_data <= scan_data + 16'h0001;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // Answers compared in request order
  always @(posedge clk) if (psel && penable && pready) begin
    chk_bit(pslverr, err_q.pop_front());
    if (!pwrite) chk_word(prdata & msk_q.pop_front(), exp_q.pop_front());
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hffff_ffff, input logic e = 1'b0);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0;
    err_q.push_back(e);
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reset_dut;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic pulse(input logic b);
    @(posedge clk);
    if (b) fire_b <= 1'b1;
    else fire_a <= 1'b1;
    ext_pin <= 1'b1;
    @(posedge clk);
    fire_a  <= 1'b0;
    fire_b  <= 1'b0;
    ext_pin <= 1'b0;
  endtask

  task automatic wait_done;
    int i = 0;
    while (done !== 1'b1 && i < 500) begin
      @(posedge clk);
      i++;
    end
  endtask

  task automatic read_data(input logic [15:0] first, input int n);
    for (int k = 0; k < n; k++) apb(1'b0, OFS_DATA, {16'h0, first + 16'(k)}, 32'h0000_ffff);
  endtask

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    rnd = $random(seed);
    reset_dut();
    apb(1'b0, OFS_DIV, RST_DIV);
    apb(1'b0, OFS_LEVEL, {RST_WINDOW, RST_LEVEL});
    apb(1'b0, OFS_STATUS, 32'h0, 32'hf);
    apb(1'b1, OFS_TOTAL, rnd);
    apb(1'b0, OFS_TOTAL, rnd);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    for (int t = 0; t < 6; t++) begin
      apb(1'b1, OFS_TRIG, 32'h9 + 32'(t));
      apb(1'b0, OFS_TRIG, texp[t], tmsk[t]);
    end
    ////////////////////////////////////////////////////////////////////////////
    reset_dut();
    apb(1'b1, OFS_DIV, 32'h1);
    apb(1'b1, OFS_TOTAL, 32'h4);
    apb(1'b1, OFS_TRIG, 32'h0a);
    base = scan_data;
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h1, 32'hf);
    chk_word({16'h0, scan_data}, {16'h0, base});
    pulse(1'b0);
    wait_done();
    apb(1'b0, OFS_STATUS, 32'h0004_0004, 32'hffff_000f);
    read_data(base, 4);
    apb(1'b1, OFS_TRIG, 32'h0b);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_STATUS, 32'hc, 32'hf);
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b0, OFS_STATUS, 32'h4, 32'hf);
    ////////////////////////////////////////////////////////////////////////////
    reset_dut();
    apb(1'b1, OFS_DIV, 32'h1);
    apb(1'b1, OFS_TOTAL, 32'h6);
    apb(1'b1, OFS_PRETRIG, 32'h3);
    apb(1'b1, OFS_TRIG, 32'h0c);
    apb(1'b1, OFS_TRIG, 32'h1a);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h2, 32'h7);
    repeat (12) @(posedge clk);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    mark = scan_data;
    repeat (10) @(posedge clk);
    chk_word({16'h0, scan_data}, {16'h0, mark});
    chk_bit(active, 1'b0);
    pulse(1'b0);
    apb(1'b0, OFS_STATUS, 32'h3, 32'h7);
    gate <= 1'b1;
    wait_done();
    read_data(mark - 16'h3, 6);
    ////////////////////////////////////////////////////////////////////////////
    reset_dut();
    apb(1'b1, OFS_DIV, 32'h1);
    apb(1'b1, OFS_TOTAL, 32'h4);
    apb(1'b1, OFS_PRETRIG, 32'h2);
    apb(1'b1, OFS_TRIG, 32'h0b);
    apb(1'b1, OFS_TRIG, 32'h1a);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h1, 32'h7);
    pulse(1'b1);
    apb(1'b0, OFS_STATUS, 32'h2, 32'h7);
    repeat (8) @(posedge clk);
    pulse(1'b0);
    wait_done();
    apb(1'b0, OFS_STATUS, 32'h0004_0004, 32'hffff_0007);
    ////////////////////////////////////////////////////////////////////////////
    reset_dut();
    apb(1'b1, OFS_LEVEL, 32'h0000_1000);
    apb(1'b1, OFS_CTRL, 32'h40);
    apb(1'b1, OFS_TRIG, 32'h2e);
    ramp <= 1'b1;
    repeat (40) @(posedge clk);
    chk_bit(cmp_out, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h10, 32'h10);
    ramp   <= 1'b0;
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    // Clock enable low freezes the comparator state
    chk_bit(cmp_out, 1'b1);
    clk_en <= 1'b1;
    repeat (10) @(posedge clk);
    chk_bit(cmp_out, 1'b0);
    results();
  end
endmodule
